/* File: hdl/smm_pkg.sv */
// shared constants and types for the management-mode memory and state save block
// Summary of operation
// - standard hidden region is 128 KB at top_of_memory+896 KB up to +1 MB
// - legacy A0000h window redirects to standard hidden region when enabled for access
// - extended hidden region is 896 KB from top_of_memory, decoded without redirection
// - while standard config active, video_alias_base+A0000h..BFFFFh reaches video buffer
// - high config forms one 1 MB hidden region from top_of_memory
// - minimum space is base+8000h..base+FFFFh; handler entry at base+8000h
// - smm_base_address resets to 30000h, entry point 38000h
// - on return load base from save map; misaligned to 32 KB means shutdown
// - smm_window_open_bit opens hidden memory; firmware clears it afterwards
// - smm_config_lock_bit locks the hidden memory configuration
// - on interrupt, save current state into save area before handler starts
// - save offsets relative to entry point; base stored at 7EF8-7EFBh
// - revision word: bit 17 relocation, bit 16 I/O restart, 15:0 version
// - on return, 00FFh at 7F00h re-executes I/O, 0000h continues
// - bit 0 at 7F02h shows halt at entry; on return 1 resumes halt
// - hidden memory always cacheable, caches kept coherent, no flush needed
package smm_pkg;
    // ****************************************
    // register bus map
    // ****************************************
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_TOM = 12'h004;
    localparam logic [11:0] REG_VIDEO_ALIAS_BASE = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam logic [11:0] REG_SMM_BASE_ADDRESS = 12'h010;
    localparam logic [11:0] SAVE_WIN_BASE = 12'h200;
    localparam logic [11:0] SAVE_WIN_MASK = 12'he00;
    // control bit positions
    localparam int CTRL_OPEN = 0;
    localparam int CTRL_LOCK = 1;
    localparam int CTRL_STD = 2;
    localparam int CTRL_EXT = 3;
    localparam int CTRL_HIGH = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // status bit positions
    localparam int STAT_INSMM = 0;
    localparam int STAT_SHUT = 1;
    localparam int STAT_HALT = 2;
    localparam int STAT_BUSY = 3;
    // ****************************************
    // address map of hidden memory
    // ****************************************
    localparam logic [31:0] LEG_BASE = 32'h000a0000;
    localparam logic [31:0] LEG_SIZE = 32'h00020000;
    localparam logic [31:0] STD_OFS = 32'h000e0000;
    localparam logic [31:0] EXT_SIZE = 32'h000e0000;
    localparam logic [31:0] HIGH_SIZE = 32'h00100000;
    localparam logic [31:0] GRAN_MASK = 32'hfff00000;
    localparam logic [31:0] SMM_BASE_ADDRESS_RST = 32'h00030000;
    localparam logic [31:0] ENTRY_OFS = 32'h00008000;
    localparam logic [31:0] ALIGN_MASK = 32'h00007fff;
    // ****************************************
    // save map word indices (offset - 7E00h) / 4
    // ****************************************
    localparam int SAVE_WORDS = 128;
    localparam int SAVE_AW = 7;
    localparam logic [6:0] IDX_BASE = 7'h3e;
    localparam logic [6:0] IDX_REV = 7'h3f;
    localparam logic [6:0] IDX_IOHALT = 7'h40;
    localparam logic [6:0] IDX_EIP = 7'h7c;
    localparam logic [6:0] IDX_EFLAGS = 7'h7d;
    localparam logic [6:0] IDX_CR3 = 7'h7e;
    localparam logic [6:0] IDX_CR0 = 7'h7f;
    localparam logic [15:0] IO_RESTART = 16'h00ff;
    localparam logic [15:0] IO_NEXT = 16'h0000;
    localparam int HALT_BIT = 16;
    localparam int REV_RELOC_BIT = 17;
    localparam int REV_IO_BIT = 16;
    localparam logic [2:0] SAVE_LAST = 3'h6;
    typedef enum {ST_IDLE, ST_SAVE, ST_RES_BASE, ST_RES_FLAGS, ST_RES_FIN, ST_SHUT} fsm_t;
    typedef enum {AB_IDLE, AB_PEND, AB_RDWAIT, AB_RDCAP} abus_t;
    typedef enum logic [1:0] {ROUTE_DRAM, ROUTE_VIDEO, ROUTE_HIDDEN, ROUTE_BLOCK} route_t;
endpackage

/* File: hdl/save_ram_if.sv */
// port bundle between the save map memory and its user
`timescale 1ns/1ns
`default_nettype none
interface save_ram_if #(parameter int AW = 7);
    logic we;
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport user (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: hdl/save_map_ram.sv */
// single-port memory holding the 512-byte state save map
`timescale 1ns/1ns
`default_nettype none
module save_map_ram #(
    parameter int WORDS = 128,
    parameter int AW = 7
) (
    input wire logic core_clk, // core clock
    save_ram_if.mem port // access port
);
    logic [31:0] mem [WORDS];

    // read first, registered read; contents are not reset, like plain ram
    always_ff @(posedge core_clk) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        port.rdata <= mem[port.addr];
    end
endmodule
`default_nettype wire

/* File: hdl/smm_space_ctrl.sv */
// management-mode address decoder, base control and state save sequencer
`timescale 1ns/1ns
`default_nettype none
module smm_space_ctrl
    import smm_pkg::*;
#(
    parameter logic [15:0] MODE_VERSION = 16'h0001 // arbitrary value
) (
    input wire logic core_clk, // 250 MHz core clock
    input wire logic nrst, // async reset, active low
    input wire logic hsel, // ahb select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, word only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic [31:0] hrdata, // ahb read data
    output logic hresp, // ahb response, always okay
    input wire logic smiReq, // interrupt taken pulse
    input wire logic rsmReq, // return instruction pulse
    input wire logic cpuHalted, // core halted level
    input wire logic [31:0] cpuEip, // core instruction pointer
    input wire logic [31:0] cpuEflags, // core flags
    input wire logic [31:0] cpuCr3, // core cr3
    input wire logic [31:0] cpuCr0, // core cr0
    input wire logic memValid, // core memory access valid
    input wire logic [31:0] memAddr, // core memory address
    output logic inSmm, // management mode active
    output logic handlerStart, // pulse, handler may run
    output logic [31:0] handlerEntry, // base plus 8000h
    output logic resumeDone, // pulse, return finished
    output logic restartIo, // re-execute io instruction
    output logic resumeHalt, // return to halt state
    output logic shutdown, // misaligned base on return
    output logic routeValid, // decode result valid
    output route_t routeTarget, // decode destination
    output logic [31:0] physAddr, // translated address
    output logic cacheable // destination cacheable
);
    // ****************************************
    // state
    // ****************************************
    logic [4:0] ctrl_q;
    logic [31:0] tom_q, video_alias_base_q, smm_base_address_q;
    fsm_t fsm_q;
    abus_t ab_q;
    logic [2:0] step_q;
    logic [31:0] snapEip_q, snapEflags_q, snapCr3_q, snapCr0_q;
    logic snapHalt_q, smiPend_q;
    logic [31:0] newBase_q;
    logic [11:0] aAddr_q;
    logic aWr_q, aRegWr_q;
    save_ram_if #(.AW(SAVE_AW)) ram ();

    save_map_ram #(.WORDS(SAVE_WORDS), .AW(SAVE_AW)) u_ram (
        .core_clk(core_clk),
        .port(ram.mem)
    );

    // wrapping compare keeps one subtractor per window
    function automatic logic inRange(input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
        return (a - b) < s;
    endfunction

    function automatic logic saveSel(input logic [11:0] a);
        return (a & SAVE_WIN_MASK) == SAVE_WIN_BASE;
    endfunction

    // ****************************************
    // register bus
    // ****************************************
    logic aTake, aSave;
    assign aTake = hsel & htrans[1] & hready;
    assign aSave = saveSel(haddr[11:0]);

    // register read mux for the zero-wait path
    function automatic logic [31:0] regRead(input logic [11:0] a);
        logic [31:0] v;
        v = 32'h0;
        if (a == REG_CTRL) begin
            v = {27'h0, ctrl_q};
        end else if (a == REG_TOM) begin
            v = tom_q;
        end else if (a == REG_VIDEO_ALIAS_BASE) begin
            v = video_alias_base_q;
        end else if (a == REG_STATUS) begin
            v[STAT_INSMM] = inSmm;
            v[STAT_SHUT] = shutdown;
            v[STAT_HALT] = snapHalt_q;
            v[STAT_BUSY] = (fsm_q != ST_IDLE);
        end else if (a == REG_SMM_BASE_ADDRESS) begin
            v = smm_base_address_q;
        end
        return v;
    endfunction

    // save map accesses always take a wait state and queue behind the sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ab_q <= AB_IDLE;
            hreadyout <= 1'b1;
            hrdata <= 32'h0;
            aAddr_q <= 12'h0;
            aWr_q <= 1'b0;
            aRegWr_q <= 1'b0;
        end else begin
            aRegWr_q <= aTake & hwrite & !aSave;
            case (ab_q)
                AB_IDLE: begin
                    if (aTake) begin
                        aAddr_q <= haddr[11:0];
                        aWr_q <= hwrite;
                        if (aSave) begin
                            ab_q <= AB_PEND;
                            hreadyout <= 1'b0;
                        end else if (!hwrite) begin
                            hrdata <= regRead(haddr[11:0]);
                        end
                    end
                end
                AB_PEND: begin
                    if (fsm_q == ST_IDLE) begin
                        ab_q <= aWr_q ? AB_IDLE : AB_RDWAIT;
                        hreadyout <= aWr_q;
                    end
                end
                AB_RDWAIT: begin
                    ab_q <= AB_RDCAP;
                end
                AB_RDCAP: begin
                    hrdata <= ram.rdata;
                    hreadyout <= 1'b1;
                    ab_q <= AB_IDLE;
                end
                default: ab_q <= AB_IDLE;
            endcase
        end
    end

    // the response never signals an error
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // control writes; lock freezes the layout and keeps the window shut
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
            tom_q <= 32'h0;
            video_alias_base_q <= 32'h0;
        end else if (aRegWr_q && !ctrl_q[CTRL_LOCK]) begin
            if (aAddr_q == REG_CTRL) begin
                ctrl_q <= hwdata[4:0];
                if (hwdata[CTRL_LOCK]) begin
                    ctrl_q[CTRL_OPEN] <= 1'b0;
                end
            end else if (aAddr_q == REG_TOM) begin
                tom_q <= hwdata & GRAN_MASK;
            end else if (aAddr_q == REG_VIDEO_ALIAS_BASE) begin
                video_alias_base_q <= hwdata & GRAN_MASK;
            end
        end
    end

    // ****************************************
    // save map port sharing
    // ****************************************
    logic [31:0] revWord;
    assign revWord = {14'h0, 1'b1, 1'b1, MODE_VERSION};

    // sequencer owns the port; queued bus access runs only when it is idle
    always_comb begin
        ram.we = 1'b0;
        ram.addr = aAddr_q[8:2];
        ram.wdata = hwdata;
        case (fsm_q)
            ST_SAVE: begin
                ram.we = 1'b1;
                case (step_q)
                    3'h0: begin ram.addr = IDX_BASE; ram.wdata = smm_base_address_q; end
                    3'h1: begin ram.addr = IDX_REV; ram.wdata = revWord; end
                    3'h2: begin
                        ram.addr = IDX_IOHALT;
                        ram.wdata = {15'h0, snapHalt_q, IO_NEXT};
                    end
                    3'h3: begin ram.addr = IDX_EIP; ram.wdata = snapEip_q; end
                    3'h4: begin ram.addr = IDX_EFLAGS; ram.wdata = snapEflags_q; end
                    3'h5: begin ram.addr = IDX_CR3; ram.wdata = snapCr3_q; end
                    default: begin ram.addr = IDX_CR0; ram.wdata = snapCr0_q; end
                endcase
            end
            ST_RES_BASE: ram.addr = IDX_BASE;
            ST_RES_FLAGS: ram.addr = IDX_IOHALT;
            ST_IDLE: ram.we = (ab_q == AB_PEND) & aWr_q;
            default: ram.we = 1'b0;
        endcase
    end

    // ****************************************
    // entry and return sequencer
    // ****************************************
    logic enterNow;
    assign enterNow = (smiReq | smiPend_q) & !inSmm & (fsm_q == ST_IDLE) & (ab_q != AB_PEND);

    // state is snapshotted at the interrupt so later core changes cannot tear it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            snapEip_q <= 32'h0;
            snapEflags_q <= 32'h0;
            snapCr3_q <= 32'h0;
            snapCr0_q <= 32'h0;
            snapHalt_q <= 1'b0;
        end else if (enterNow) begin
            snapEip_q <= cpuEip;
            snapEflags_q <= cpuEflags;
            snapCr3_q <= cpuCr3;
            snapCr0_q <= cpuCr0;
            snapHalt_q <= cpuHalted;
        end
    end

    // an interrupt during the mode is held and taken right after the return
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            smiPend_q <= 1'b0;
        end else if (smiReq && !enterNow) begin
            smiPend_q <= 1'b1;
        end else if (enterNow) begin
            smiPend_q <= 1'b0;
        end
    end

    // save first, then release the handler; return checks the base alignment
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fsm_q <= ST_IDLE;
            step_q <= 3'h0;
            inSmm <= 1'b0;
            handlerStart <= 1'b0;
            resumeDone <= 1'b0;
            restartIo <= 1'b0;
            resumeHalt <= 1'b0;
            shutdown <= 1'b0;
            smm_base_address_q <= SMM_BASE_ADDRESS_RST;
            newBase_q <= 32'h0;
        end else begin
            handlerStart <= 1'b0;
            resumeDone <= 1'b0;
            case (fsm_q)
                ST_IDLE: begin
                    if (enterNow) begin
                        fsm_q <= ST_SAVE;
                        step_q <= 3'h0;
                        inSmm <= 1'b1;
                    end else if (rsmReq && inSmm && ab_q != AB_PEND) begin
                        fsm_q <= ST_RES_BASE;
                    end
                end
                ST_SAVE: begin
                    step_q <= step_q + 3'h1;
                    if (step_q == SAVE_LAST) begin
                        fsm_q <= ST_IDLE;
                        handlerStart <= 1'b1;
                    end
                end
                ST_RES_BASE: fsm_q <= ST_RES_FLAGS;
                ST_RES_FLAGS: begin
                    newBase_q <= ram.rdata;
                    fsm_q <= ST_RES_FIN;
                end
                ST_RES_FIN: begin
                    if ((newBase_q & ALIGN_MASK) != 32'h0) begin
                        shutdown <= 1'b1;
                        fsm_q <= ST_SHUT;
                    end else begin
                        smm_base_address_q <= newBase_q;
                        restartIo <= (ram.rdata[15:0] == IO_RESTART);
                        resumeHalt <= ram.rdata[HALT_BIT];
                        inSmm <= 1'b0;
                        resumeDone <= 1'b1;
                        fsm_q <= ST_IDLE;
                    end
                end
                ST_SHUT: fsm_q <= ST_SHUT;
                default: fsm_q <= ST_IDLE;
            endcase
        end
    end

    // entry point follows the base
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            handlerEntry <= SMM_BASE_ADDRESS_RST + ENTRY_OFS;
        end else begin
            handlerEntry <= smm_base_address_q + ENTRY_OFS;
        end
    end

    // ****************************************
    // address decoder
    // ****************************************
    route_t tgt;
    logic [31:0] pa;
    logic allow;
    assign allow = inSmm | ctrl_q[CTRL_OPEN];

    // legacy window first, then the alias, then the regions at top of memory
    always_comb begin
        tgt = ROUTE_DRAM;
        pa = memAddr;
        if (inRange(memAddr, LEG_BASE, LEG_SIZE)) begin
            tgt = ROUTE_VIDEO;
            if (ctrl_q[CTRL_STD] && allow) begin
                tgt = ROUTE_HIDDEN;
                pa = tom_q + STD_OFS + (memAddr - LEG_BASE);
            end
        end else if (ctrl_q[CTRL_STD] && inRange(memAddr, video_alias_base_q + LEG_BASE, LEG_SIZE)) begin
            tgt = ROUTE_VIDEO;
            pa = memAddr - video_alias_base_q;
        end else if ((ctrl_q[CTRL_HIGH] && inRange(memAddr, tom_q, HIGH_SIZE)) ||
                     (ctrl_q[CTRL_EXT] && inRange(memAddr, tom_q, EXT_SIZE))) begin
            tgt = allow ? ROUTE_HIDDEN : ROUTE_BLOCK;
        end
    end

    // one cycle of decode latency; hidden space is always cacheable
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            routeValid <= 1'b0;
            routeTarget <= ROUTE_DRAM;
            physAddr <= 32'h0;
            cacheable <= 1'b0;
        end else begin
            routeValid <= memValid;
            routeTarget <= tgt;
            physAddr <= pa;
            cacheable <= (tgt == ROUTE_HIDDEN) | (tgt == ROUTE_DRAM);
        end
    end
endmodule
`default_nettype wire

/* File: test/smm_space_ctrl_asserts.sv */
// port assertions for the management-mode block
`timescale 1ns/1ns
`default_nettype none
module smm_space_ctrl_asserts
    import smm_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic nrst, // reset
    input wire logic inSmm, // mode
    input wire logic handlerStart, // start pulse
    input wire logic [31:0] handlerEntry, // entry
    input wire logic resumeDone, // return pulse
    input wire logic shutdown, // stuck
    input wire logic [31:0] memAddr, // address
    input wire logic routeValid, // decode valid
    input wire route_t routeTarget, // target
    input wire logic [31:0] physAddr, // translated
    input wire logic cacheable // cache flag
);
    // ********************
    // properties
    // ********************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [31:0] prevAddr_q;
    logic hid;
    // decode answers one cycle late, so keep the address it answers for
    always_ff @(posedge core_clk) begin
        prevAddr_q <= memAddr;
    end
    assign hid = routeValid && routeTarget == ROUTE_HIDDEN;
    a_entry_after_reset: assert property ($rose(nrst) |-> handlerEntry == 32'h00038000)
        else $error("entry point wrong after reset");
    a_entry_aligned: assert property (handlerEntry[14:0] == 15'h0000)
        else $error("entry point not aligned");
    a_save_then_start: assert property ($rose(inSmm) |-> !handlerStart ##[5:9] handlerStart)
        else $error("handler start not after save");
    a_done_leaves_mode: assert property (resumeDone |-> !inSmm && !shutdown)
        else $error("return left mode wrongly");
    a_shut_sticky: assert property (shutdown |=> shutdown && inSmm)
        else $error("shutdown released");
    a_hidden_cached: assert property (hid |-> cacheable)
        else $error("hidden memory not cacheable");
    a_legacy_redirect: assert property (hid && prevAddr_q[31:17] == 15'h0005 |->
        physAddr[19:0] == {3'h7, prevAddr_q[16:0]})
        else $error("legacy redirect wrong");
    a_video_window: assert property (routeValid && routeTarget == ROUTE_VIDEO |-> physAddr[31:17] == 15'h0005)
        else $error("video access outside frame buffer");
    a_hidden_identity: assert property (hid && prevAddr_q[31:17] != 15'h0005 |-> physAddr == prevAddr_q)
        else $error("hidden access translated");
    c_start: cover property (handlerStart);
    c_done: cover property (resumeDone);
    c_shut: cover property (shutdown);
    c_hid: cover property (hid);
endmodule
bind smm_space_ctrl smm_space_ctrl_asserts i_asserts (.core_clk, .nrst, .inSmm, .handlerStart, .handlerEntry,
    .resumeDone, .shutdown, .memAddr, .routeValid, .routeTarget, .physAddr, .cacheable);
`default_nettype wire

/* File: test/smm_core_model.sv */
// southbridge and handler side: interrupt and return pulses
`timescale 1ns/1ns
`default_nettype none
module smm_core_model (
    input wire logic core_clk, // clock
    input wire logic nrst, // reset
    input wire logic smiCmd, // bench asks for a test interrupt
    input wire logic rsmCmd, // handler done
    input wire logic inSmm, // mode active
    output logic smiReq, // interrupt pulse
    output logic rsmReq // return pulse
);
    logic smiCmd_q;
    logic rsmCmd_q;
    // edge detect: a held command still yields one pulse, as the bridge does
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            smiCmd_q <= 1'b0;
            rsmCmd_q <= 1'b0;
            smiReq <= 1'b0;
            rsmReq <= 1'b0;
        end else begin
            smiCmd_q <= smiCmd;
            rsmCmd_q <= rsmCmd;
            smiReq <= smiCmd && !smiCmd_q;
            rsmReq <= rsmCmd && !rsmCmd_q && inSmm; // return only runs inside the handler
        end
    end
endmodule
`default_nettype wire

/* File: test/sysmgmt_memory_and_state_save_tb_top.sv */
// self-checking bench for smm_space_ctrl
`timescale 1ns/1ns
`default_nettype none
module sysmgmt_memory_and_state_save_tb_top;
    import smm_pkg::*;
    // ********************
    // signals and helpers
    // ********************
    logic core_clk, nrst, hsel, hwrite, smiCmd, rsmCmd, smiReq, rsmReq, cpuHalted, memValid;
    logic hreadyout, hresp, inSmm, handlerStart, resumeDone, restartIo, resumeHalt, shutdown, routeValid, cacheable;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, cpuEip, cpuEflags, cpuCr3, cpuCr0, memAddr, handlerEntry, physAddr;
    logic [31:0] lfsr, rd, a;
    logic [31:0] top_of_memory = 32'h01000000;
    logic [31:0] vw = 32'h00100000;
    route_t routeTarget;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    smm_space_ctrl i_dut (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .smiReq, .rsmReq, .cpuHalted, .cpuEip, .cpuEflags, .cpuCr3, .cpuCr0,
        .memValid, .memAddr, .inSmm, .handlerStart, .handlerEntry, .resumeDone, .restartIo, .resumeHalt,
        .shutdown, .routeValid, .routeTarget, .physAddr, .cacheable);
    smm_core_model i_core (.core_clk, .nrst, .smiCmd, .rsmCmd, .inSmm, .smiReq, .rsmReq);
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // legacy access redirected above top of memory
    function automatic logic [31:0] leg_phys(input logic [31:0] x);
        return top_of_memory + 32'h000e0000 + (x - 32'h000a0000);
    endfunction
    task automatic complete_run();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single word transfer; entered just after a clock edge
    task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= ad;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic dec(input logic [31:0] ad, input route_t t);
        memValid <= 1'b1;
        memAddr <= ad;
        @(posedge core_clk);
        memValid <= 1'b0;
        @(posedge core_clk);
        check({30'h0, routeTarget}, {30'h0, t});
    endtask
    // bounded wait on start pulse, return pulse or shutdown
    task automatic wait_for(input int sel);
        int n;
        n = 0;
        while (n < 40 && (sel == 0 ? handlerStart : sel == 1 ? resumeDone : shutdown) !== 1'b1) begin
            @(posedge core_clk);
            n++;
        end
        check(32'(n < 40), 32'h1);
    endtask
    task automatic enter(input logic h, input logic [31:0] base);
        lfsr = next_rand(lfsr);
        cpuEip <= lfsr;
        cpuEflags <= ~lfsr;
        cpuCr3 <= {lfsr[15:0], lfsr[31:16]};
        cpuCr0 <= lfsr ^ 32'h5a5a5a5a;
        cpuHalted <= h;
        smiCmd <= 1'b1;
        @(posedge core_clk);
        smiCmd <= 1'b0;
        wait_for(0);
        check({31'h0, inSmm}, 32'h1);
        xfer(1'b0, 32'h2f8, 32'h0);
        check(rd, base);
        xfer(1'b0, 32'h2fc, 32'h0);
        check(rd, 32'h00030001);
        xfer(1'b0, 32'h300, 32'h0);
        check(rd, {15'h0, h, 16'h0000});
        xfer(1'b0, 32'h3f0, 32'h0);
        check(rd, cpuEip);
        xfer(1'b0, 32'h3fc, 32'h0);
        check(rd, cpuCr0);
    endtask
    // handler edits only documented save fields, then returns
    task automatic leave(input logic [31:0] base, input logic [31:0] io);
        xfer(1'b1, 32'h2f8, base);
        xfer(1'b1, 32'h300, io);
        rsmCmd <= 1'b1;
        @(posedge core_clk);
        rsmCmd <= 1'b0;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // a hang ends the run as a failure
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    // ********************
    // main sequence
    // ********************
    initial begin
        {nrst, hsel, hwrite, smiCmd, rsmCmd, cpuHalted, memValid, htrans, hsize} = '0;
        {haddr, hwdata, cpuEip, cpuEflags, cpuCr3, cpuCr0, memAddr} = '0;
        lfsr = 32'h9e654658;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        check(handlerEntry, 32'h00038000);
        xfer(1'b0, 32'h010, 32'h0);
        check(rd, 32'h00030000);
        xfer(1'b1, 32'h004, top_of_memory);
        xfer(1'b1, 32'h008, vw);
        xfer(1'b1, 32'h000, 32'h04);
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            a = 32'h000a0000 + {15'h0, lfsr[16:2], 2'b00};
            dec(a, ROUTE_VIDEO);
            check(physAddr, a);
            dec(vw + a, ROUTE_VIDEO);
            check(physAddr, a);
            dec(top_of_memory + a, ROUTE_DRAM);
        end
        xfer(1'b1, 32'h000, 32'h05);
        dec(a, ROUTE_HIDDEN);
        check(physAddr, leg_phys(a));
        xfer(1'b1, 32'h000, 32'h0c);
        dec(top_of_memory + 32'h100, ROUTE_BLOCK);
        xfer(1'b1, 32'h000, 32'h0d);
        dec(top_of_memory + 32'h000dfffc, ROUTE_HIDDEN);
        check(physAddr, top_of_memory + 32'h000dfffc);
        dec(top_of_memory + 32'h000e0000, ROUTE_DRAM);
        xfer(1'b1, 32'h000, 32'h11);
        dec(top_of_memory + 32'h000ffffc, ROUTE_HIDDEN);
        xfer(1'b1, 32'h000, 32'h04);
        enter(1'b1, 32'h00030000);
        dec(a, ROUTE_HIDDEN);
        leave(32'h00048000, 32'h000100ff);
        wait_for(1);
        @(posedge core_clk);
        check({30'h0, restartIo, resumeHalt}, 32'h3);
        check(handlerEntry, 32'h00050000);
        enter(1'b0, 32'h00048000);
        leave(32'h00048000, 32'h0);
        wait_for(1);
        check({30'h0, restartIo, resumeHalt}, 32'h0);
        xfer(1'b1, 32'h000, 32'h16);
        xfer(1'b1, 32'h000, 32'h01);
        xfer(1'b1, 32'h004, 32'h0);
        xfer(1'b0, 32'h000, 32'h0);
        check(rd, 32'h16);
        xfer(1'b0, 32'h004, 32'h0);
        check(rd, top_of_memory);
        xfer(1'b0, 32'h040, 32'h0);
        check(rd, 32'h0);
        enter(1'b1, 32'h00048000);
        leave(32'h00048100, 32'h0);
        wait_for(2);
        check({30'h0, shutdown, inSmm}, 32'h3);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        check(handlerEntry, 32'h00038000);
        xfer(1'b1, 32'h2f8, 32'h00048100);
        xfer(1'b0, 32'h2f8, 32'h0);
        check(rd, 32'h00048100);
        complete_run();
    end
endmodule
`default_nettype wire
